// ===== core/uart_flow_pkg.sv
// Constants for the channel flow and error control block
package uart_flow_pkg;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [15:0] ADDR_CHANNEL_ENABLE = 16'h0000;
	localparam logic [15:0] ADDR_FLOW_SELECT = 16'h0006;
	localparam logic [15:0] ADDR_RESUME_CHARACTER = 16'h0007;
	localparam logic [15:0] ADDR_PAUSE_CHARACTER = 16'h0008;
	localparam logic [15:0] ADDR_LINE_ERROR_FLAGS = 16'h0009;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_TX_ENABLE = 0;
	localparam int BIT_RX_ENABLE = 1;
	localparam int BIT_HALF_DUPLEX = 3;
	localparam int BIT_BREAK_ERR = 3;
	localparam int BIT_FRAMING_ERR = 4;
	localparam int BIT_PARITY_ERR = 5;
	localparam int BIT_OVERRUN_ERR = 6;
	localparam int BIT_BREAK_LIVE = 7;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [1:0] RESET_ENABLE = 2'h0;
	localparam logic [3:0] RESET_FLOW_SELECT = 4'h0;
	localparam logic [7:0] RESET_RESUME_CHARACTER = 8'h11;
	localparam logic [7:0] RESET_PAUSE_CHARACTER = 8'h13;
	localparam logic [3:0] RESET_ERROR_FLAGS = 4'h0;
	// ----------------------------------------
	// Flow mode codes
	// ----------------------------------------
	localparam logic [2:0] MODE_NONE = 3'h0;
	localparam logic [2:0] MODE_HARDWARE = 3'h1;
	localparam logic [2:0] MODE_SOFTWARE = 3'h2;
	localparam logic [2:0] MODE_ADDR_RX = 3'h3;
	localparam logic [2:0] MODE_ADDR_BOTH = 3'h4;
endpackage

// ===== core/uart_flow_ctrl.sv
// Flow control, enables and line error status for one UART channel
`timescale 1ns/1ps
module uart_flow_ctrl
	import uart_flow_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Vendor register requests
	input wire logic vendor_write_request_i,
	input wire logic vendor_read_request_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// Receiver events
	input wire logic rx_char_valid_i,
	input wire logic [8:0] rx_char_i,
	input wire logic [3:0] char_bits_i,
	input wire logic rx_fifo_full_i,
	input wire logic parity_err_i,
	input wire logic framing_err_i,
	input wire logic break_detect_i,
	input wire logic break_live_i,
	// Transmitter state
	input wire logic tx_busy_i,
	// Channel control
	output logic tx_allow_o,
	output logic rx_accept_o,
	output logic hw_flow_o,
	output logic addr_matched_o
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [1:0] channel_enable;
	logic [3:0] flow_select;
	logic [7:0] resume_character;
	logic [7:0] pause_character;
	logic [3:0] error_flags;
	logic paused;
	logic matched;
	logic [2:0] mode;
	logic discard;
	logic ev_valid;
	logic [8:0] cmp_mask;
	logic [8:0] rx_masked;
	logic is_resume;
	logic is_pause;
	logic is_address;
	logic [3:0] err_events;
	logic err_read;

	assign mode = flow_select[2:0];
	assign discard = flow_select[BIT_HALF_DUPLEX] & tx_busy_i;
	assign ev_valid = rx_char_valid_i & channel_enable[BIT_RX_ENABLE] & ~discard;
	assign is_address = rx_char_i[8];

	// ----------------------------------------
	// Character compare mask
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 9; g++) begin : g_mask
			assign cmp_mask[g] = (g < 8) ? (4'(g) < char_bits_i) : (char_bits_i > 4'h8);
		end
	endgenerate

	assign rx_masked = rx_char_i & cmp_mask;
	assign is_resume = rx_masked == ({1'b0, resume_character} & cmp_mask);
	assign is_pause = rx_masked == ({1'b0, pause_character} & cmp_mask);

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			channel_enable <= RESET_ENABLE;
			flow_select <= RESET_FLOW_SELECT;
			resume_character <= RESET_RESUME_CHARACTER;
			pause_character <= RESET_PAUSE_CHARACTER;
		end else if (vendor_write_request_i) begin
			if (reg_addr_i == ADDR_CHANNEL_ENABLE) begin
				channel_enable <= reg_wdata_i[1:0];
			end else if (reg_addr_i == ADDR_FLOW_SELECT) begin
				flow_select <= reg_wdata_i[3:0];
			end else if (reg_addr_i == ADDR_RESUME_CHARACTER) begin
				resume_character <= reg_wdata_i[7:0];
			end else if (reg_addr_i == ADDR_PAUSE_CHARACTER) begin
				pause_character <= reg_wdata_i[7:0];
			end
		end
	end

	// ----------------------------------------
	// Software flow control
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			paused <= 1'b0;
		end else if (mode != MODE_SOFTWARE) begin
			paused <= 1'b0;
		end else if (ev_valid && is_pause) begin
			paused <= 1'b1;
		end else if (ev_valid && is_resume) begin
			paused <= 1'b0;
		end
	end

	// ----------------------------------------
	// Address matching
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			matched <= 1'b0;
		end else if (mode != MODE_ADDR_RX && mode != MODE_ADDR_BOTH) begin
			matched <= 1'b0;
		end else if (ev_valid && is_address) begin
			matched <= (rx_char_i[7:0] == resume_character) || (rx_char_i[7:0] == pause_character);
		end
	end

	// ----------------------------------------
	// Error status
	// ----------------------------------------
	assign err_events = {ev_valid & rx_fifo_full_i,
		ev_valid & parity_err_i,
		ev_valid & framing_err_i,
		channel_enable[BIT_RX_ENABLE] & break_detect_i};
	assign err_read = vendor_read_request_i && reg_addr_i == ADDR_LINE_ERROR_FLAGS;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			error_flags <= RESET_ERROR_FLAGS;
		end else if (err_read) begin
			error_flags <= err_events;
		end else begin
			error_flags <= error_flags | err_events;
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 16'h0000;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= vendor_read_request_i;
			if (!vendor_read_request_i) begin
				reg_rdata_o <= 16'h0000;
			end else if (reg_addr_i == ADDR_CHANNEL_ENABLE) begin
				reg_rdata_o <= {14'h0000, channel_enable};
			end else if (reg_addr_i == ADDR_FLOW_SELECT) begin
				reg_rdata_o <= {12'h000, flow_select};
			end else if (reg_addr_i == ADDR_RESUME_CHARACTER) begin
				reg_rdata_o <= {8'h00, resume_character};
			end else if (reg_addr_i == ADDR_PAUSE_CHARACTER) begin
				reg_rdata_o <= {8'h00, pause_character};
			end else if (reg_addr_i == ADDR_LINE_ERROR_FLAGS) begin
				reg_rdata_o <= {8'h00, break_live_i, error_flags, 3'h0};
			end else begin
				reg_rdata_o <= 16'h0000;
			end
		end
	end

	// ----------------------------------------
	// Channel gating outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			tx_allow_o <= 1'b0;
			rx_accept_o <= 1'b0;
			hw_flow_o <= 1'b0;
			addr_matched_o <= 1'b0;
		end else begin
			tx_allow_o <= channel_enable[BIT_TX_ENABLE] & ~paused & (mode != MODE_ADDR_BOTH | matched);
			rx_accept_o <= channel_enable[BIT_RX_ENABLE] & ~discard
				& ((mode != MODE_ADDR_RX && mode != MODE_ADDR_BOTH) | matched);
			hw_flow_o <= mode == MODE_HARDWARE;
			addr_matched_o <= matched;
		end
	end
endmodule

// ===== tb/uart_flow_ctrl_chk.sv
// Port assertions for the channel control block
`timescale 1ns/1ps
module uart_flow_ctrl_chk
	import uart_flow_pkg::*;
(
	input wire logic ref_clk_i, rst_i, vendor_write_request_i, vendor_read_request_i,
	input wire logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
	input wire logic reg_rvalid_o, break_detect_i, break_live_i,
	input wire logic tx_allow_o, rx_accept_o, hw_flow_o, addr_matched_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	wire rd9 = vendor_read_request_i && reg_addr_i == ADDR_LINE_ERROR_FLAGS;
	wire wen = vendor_write_request_i && reg_addr_i == ADDR_CHANNEL_ENABLE;
	wire wfl = vendor_write_request_i && reg_addr_i == ADDR_FLOW_SELECT;
	property p_rv; vendor_read_request_i |=> reg_rvalid_o; endproperty
	a_rv: assert property (p_rv) else $error("read unanswered");
	property p_idle; !vendor_read_request_i |=> !reg_rvalid_o && reg_rdata_o == 16'h0000; endproperty
	a_idle: assert property (p_idle) else $error("stray read data");
	property p_live; rd9 |=> reg_rdata_o[BIT_BREAK_LIVE] == $past(break_live_i); endproperty
	a_live: assert property (p_live) else $error("live break bit wrong");
	property p_rsv; rd9 |=> reg_rdata_o[15:8] == 8'h00 && reg_rdata_o[2:0] == 3'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved flag bits set");
	property p_hw; wfl && reg_wdata_i[2:0] == 3'h1 |-> ##[2:6] hw_flow_o; endproperty
	a_hw: assert property (p_hw) else $error("handshake not on");
	property p_off; wen && reg_wdata_i[1:0] == 2'h0 |-> ##3 !tx_allow_o && !rx_accept_o; endproperty
	a_off: assert property (p_off) else $error("channel still on");
	property p_rst; disable iff (1'b0) rst_i |=> !tx_allow_o && !rx_accept_o && !hw_flow_o && !addr_matched_o; endproperty
	a_rst: assert property (p_rst) else $error("outputs not off in reset");
	property p_keep; rd9 && break_detect_i && rx_accept_o ##1 !vendor_read_request_i ##1 rd9 |=> reg_rdata_o[3]; endproperty
	a_keep: assert property (p_keep) else $error("event lost at read");
endmodule
bind uart_flow_ctrl uart_flow_ctrl_chk u_uart_flow_ctrl_chk (.*);

// ===== tb/uart_remote_model.sv
// Remote serial line model feeding received characters
`timescale 1ns/1ps
module uart_remote_model (
	input wire logic clk_i,
	output logic valid_o,
	output logic [8:0] char_o,
	output logic par_o, frm_o, brk_o
);
	initial {valid_o, char_o, par_o, frm_o, brk_o} = 13'h0;
	task automatic send(input logic [8:0] c, input logic [2:0] e);
		@(posedge clk_i) #1;
		{valid_o, char_o, par_o, frm_o, brk_o} = {1'b1, c, e};
		@(posedge clk_i) #1;
		{valid_o, char_o, par_o, frm_o, brk_o} = {1'b0, ~c, 3'h0};
	endtask
endmodule

// ===== tb/test_uart_flow_and_error_control.sv
// Testbench for the channel control block
`timescale 1ns/1ps
module test_uart_flow_and_error_control;
	logic ref_clk_i = 0, rst_i = 1, vendor_write_request_i = 0, vendor_read_request_i = 0;
	logic [15:0] reg_addr_i = 16'h0, reg_wdata_i = 16'h0, reg_rdata_o;
	logic reg_rvalid_o, tx_allow_o, rx_accept_o, hw_flow_o, addr_matched_o;
	logic rx_char_valid_i, parity_err_i, framing_err_i, break_detect_i;
	logic [8:0] rx_char_i;
	logic [3:0] char_bits_i = 4'h8;
	logic rx_fifo_full_i = 0, break_live_i = 0, tx_busy_i = 0;
	int n_fail = 0, comparisons = 0;
	uart_flow_ctrl u_uart_flow_ctrl (.*);
	uart_remote_model u_uart_remote_model (.clk_i(ref_clk_i), .valid_o(rx_char_valid_i), .char_o(rx_char_i),
		.par_o(parity_err_i), .frm_o(framing_err_i), .brk_o(break_detect_i));
	always #10 ref_clk_i = ~ref_clk_i;
	task automatic cmp(input logic [16:0] g, e);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, d);
		@(posedge ref_clk_i) #1;
		{vendor_write_request_i, vendor_read_request_i, reg_addr_i, reg_wdata_i} = {w, !w, a, w ? d : 16'h0};
		@(posedge ref_clk_i) #1;
		{vendor_write_request_i, vendor_read_request_i} = 2'b00;
		if (!w) cmp({reg_rvalid_o, reg_rdata_o}, {1'b1, d});
	endtask
	task automatic outs(input logic [3:0] e);
		repeat (2) @(posedge ref_clk_i);
		#1;
		cmp({13'h0, tx_allow_o, rx_accept_o, hw_flow_o, addr_matched_o}, {13'h0, e});
	endtask
	task automatic rx(input logic [8:0] c, input logic [2:0] e);
		u_uart_remote_model.send(c, e);
	endtask
	task automatic cfg(input logic [15:0] f, en);
		acc(1, 16'h0000, 16'h0000);
		acc(1, 16'h0006, f);
		acc(1, 16'h0000, en);
	endtask
	task automatic report_and_stop();
		if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic t_regs();
		acc(0, 16'h0000, 16'h0000);
		acc(0, 16'h0006, 16'h0000);
		acc(0, 16'h0007, 16'h0011);
		acc(0, 16'h0008, 16'h0013);
		acc(0, 16'h0009, 16'h0000);
		acc(1, 16'h0008, 16'h0025);
		acc(0, 16'h0008, 16'h0025);
		acc(1, 16'h0008, 16'h0013);
		acc(0, 16'h0001, 16'h0000);
	endtask
	task automatic t_flow();
		cfg(16'h0001, 16'h0003);
		outs(4'b1110);
		cfg(16'h0002, 16'h0003);
		rx(9'h013, 3'h0);
		outs(4'b0100);
		rx(9'h011, 3'h0);
		outs(4'b1100);
		char_bits_i = 4'h5;
		rx(9'h033, 3'h0);
		outs(4'b0100);
		rx(9'h0f1, 3'h0);
		outs(4'b1100);
		char_bits_i = 4'h9;
		rx(9'h113, 3'h0);
		outs(4'b1100);
		rx(9'h013, 3'h0);
		outs(4'b0100);
		rx(9'h011, 3'h0);
		outs(4'b1100);
		char_bits_i = 4'h8;
		cfg(16'h0000, 16'h0003);
		rx(9'h013, 3'h0);
		outs(4'b1100);
	endtask
	task automatic t_addr();
		cfg(16'h0003, 16'h0003);
		outs(4'b1000);
		rx(9'h111, 3'h0);
		outs(4'b1101);
		rx(9'h1aa, 3'h0);
		outs(4'b1000);
		cfg(16'h0004, 16'h0003);
		outs(4'b0000);
		rx(9'h113, 3'h0);
		outs(4'b1101);
	endtask
	task automatic t_err();
		cfg(16'h0000, 16'h0002);
		rx_fifo_full_i = 1;
		rx(9'h055, 3'b110);
		rx_fifo_full_i = 0;
		rx(9'h000, 3'b001);
		break_live_i = 1;
		acc(0, 16'h0009, 16'h00f8);
		acc(0, 16'h0009, 16'h0080);
		break_live_i = 0;
		fork
			acc(0, 16'h0009, 16'h0000);
			rx(9'h000, 3'b001);
		join
		acc(0, 16'h0009, 16'h0008);
		cfg(16'h0008, 16'h0002);
		tx_busy_i = 1;
		rx(9'h000, 3'b100);
		tx_busy_i = 0;
		acc(0, 16'h0009, 16'h0000);
	endtask
	initial begin
		repeat (8) @(posedge ref_clk_i);
		#1 rst_i = 0;
		t_regs();
		t_flow();
		t_addr();
		t_err();
		report_and_stop();
	end
	initial begin
		#40000;
		n_fail++;
		report_and_stop();
	end
endmodule
